// ---- ide_encoder.sv ----
// Interrupt descriptor encoder with APB registers and a level interrupt.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module ide_encoder #(
  parameter int NUM_CH = 32
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        ev_valid,
  input  wire logic        ev_dir,
  input  wire logic [3:0]  ev_group,
  input  wire logic [4:0]  ev_slot,
  input  wire logic        req_done_ok,
  input  wire logic        buf_done,
  input  wire logic        buf_done_notify_enable,
  input  wire logic        msg_done,
  input  wire logic [13:0] byte_count_field,
  input  wire logic [3:0]  ev_error,
  input  wire logic        pad_done,
  input  wire logic [7:0]  pad_count,
  input  wire logic        pad_notify_enable,
  input  wire logic        fill_valid,
  input  wire logic [7:0]  fill_octet,
  input  wire logic        framing_lost,
  input  wire logic        ss7_mode,
  input  wire logic        monitor_up,
  input  wire logic        monitor_down,
  input  wire logic        dup_unit,
  output logic             dup_discard,
  output logic [31:0]      desc_word,
  output logic             desc_valid,
  input  wire logic        desc_ready
);
  `include "ide_map.svh"

  // APB decode; every access completes in its first access cycle.
  wire        acc       = psel && penable;
  wire        wr        = acc && pwrite;
  wire        rd        = acc && !pwrite;
  wire        hit_ctrl  = (paddr == `IDE_REG_CTRL);
  wire        hit_stat  = (paddr == `IDE_REG_STAT);
  wire        hit_mask  = (paddr == `IDE_REG_MASK);
  wire        hit_desc  = (paddr == `IDE_REG_DESC);
  wire        hit_chm   = (paddr == `IDE_REG_CHMASK);
  wire        hit_cnt   = (paddr == `IDE_REG_CNT);
  wire        mapped    = hit_ctrl | hit_stat | hit_mask | hit_desc | hit_chm | hit_cnt;

  logic                 enable;
  logic [31:0]          slot_mask;
  logic [15:0]          irq_stat;
  logic [15:0]          irq_mask;
  logic [15:0]          emit_cnt;
  ide_pkg::ide_word_t   next_word;
  ide_pkg::ide_state_e  state;
  logic                 frame_lost_q;
  logic                 abt_seen;
  logic                 idl_seen;

  // Fill pattern watcher sits only on receive fill octets.
  ide_fill_watch u_fill (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .fill_valid (fill_valid && !ev_dir),
    .fill_octet (fill_octet),
    .to_abort   (abt_seen),
    .to_idle    (idl_seen)
  );

  // Framing lost edge tracking; the input is on our clock, so no synchroniser.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_lost_q <= 1'b0;
    end else begin
      frame_lost_q <= framing_lost;
    end
  end
  wire frame_back = frame_lost_q && !framing_lost;

  // Raw event conditions; pad and SS7 events are qualified by direction, buffer and pad done by their enables.
  wire c_ack  = req_done_ok;
  wire c_buf  = buf_done && buf_done_notify_enable;
  wire c_msg  = msg_done;
  wire c_pad  = ev_dir && pad_done && pad_notify_enable
                && (pad_count != 8'h00);
  wire c_abt  = abt_seen;
  wire c_idl  = idl_seen;
  wire c_frame = frame_back;
  wire c_mup  = ss7_mode && !ev_dir && monitor_up;
  wire c_mdn  = ss7_mode && !ev_dir && monitor_down;
  wire c_dup  = ss7_mode && !ev_dir && dup_unit;

  // Per-channel mask hides maskable events; acknowledge is never masked.
  wire slot_ok = !slot_mask[ev_slot];

  // Priority encoder: acknowledge first, then completion, then the rest.
  ide_pkg::ide_code_t code;
  always_comb begin
    code = `IDE_EVT_NONE;
    if (c_ack)                 code = `IDE_EVT_ACK;
    else if (!slot_ok)         code = `IDE_EVT_NONE;
    else if (c_buf)            code = `IDE_EVT_BUF;
    else if (c_msg)            code = `IDE_EVT_MSG;
    else if (c_pad)            code = `IDE_EVT_PAD;
    else if (c_abt)            code = `IDE_EVT_ABTF;
    else if (c_idl)            code = `IDE_EVT_IDLF;
    else if (c_frame)          code = `IDE_EVT_FRAME;
    else if (c_mup)            code = `IDE_EVT_MUP;
    else if (c_mdn)            code = `IDE_EVT_MDN;
    else if (c_dup)            code = `IDE_EVT_DUP;
  end

  // Only completion events may carry an error; others go out with error zero.
  wire       combinable = (code == `IDE_EVT_BUF) || (code == `IDE_EVT_MSG);
  wire [3:0] err_field  = combinable ? ev_error : `IDE_ERR_NONE;
  wire [13:0] cnt_field = (code == `IDE_EVT_BUF) ? byte_count_field : 14'h0000;

  // Descriptor assembly.
  always_comb begin
    next_word = 32'h0000_0000;
    next_word[`IDE_BIT_DIR]              = (code == `IDE_EVT_FRAME) ? 1'b0 : ev_dir;
    next_word[`IDE_SET_HI:`IDE_SET_LO]   = ev_group[1:0];
    next_word[`IDE_BIT_GRPMSB]           = ev_group[2];
    next_word[`IDE_SLOT_HI:`IDE_SLOT_LO] = ev_slot;
    next_word[`IDE_EVT_HI:`IDE_EVT_LO]   = code;
    next_word[`IDE_ERR_HI:`IDE_ERR_LO]   = err_field;
    next_word[`IDE_CNT_HI:0]             = cnt_field;
  end

  wire produce = enable && ev_valid && (code != `IDE_EVT_NONE);
  assign dup_discard = c_dup;

  // Descriptor handshake: a word is held until the queue logic takes it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state     <= ide_pkg::IDE_IDLE;
      desc_word <= 32'h0000_0000;
    end else begin
      case (state)
        ide_pkg::IDE_IDLE: begin
          if (produce) begin
            desc_word <= next_word;
            state     <= ide_pkg::IDE_EMIT;
          end
        end
        ide_pkg::IDE_EMIT: begin
          if (desc_ready) begin
            state <= ide_pkg::IDE_IDLE;
          end
        end
        default: begin
          state <= ide_pkg::IDE_IDLE;
        end
      endcase
    end
  end
  assign desc_valid = (state == ide_pkg::IDE_EMIT);
  wire taken = desc_valid && desc_ready;

  // Sticky status per event code; a new event wins over the read clear.
  logic [15:0] ev_hit;
  always_comb begin
    ev_hit = 16'h0000;
    if (produce && state == ide_pkg::IDE_IDLE) begin
      ev_hit[code] = 1'b1;
    end
  end
  wire stat_rd = rd && hit_stat;
  // A read clears only the bits it returned; a bit set after the setup capture survives.
  wire [15:0] stat_clr = stat_rd ? prdata[15:0] : 16'h0000;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat <= 16'h0000;
    end else begin
      irq_stat <= (irq_stat & ~stat_clr) | ev_hit;
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // Writable registers and the emitted descriptor counter.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable   <= 1'b0;
      slot_mask <= 32'h0000_0000;
      irq_mask <= 16'h0000;
      emit_cnt <= 16'h0000;
    end else begin
      if (wr && hit_ctrl) enable <= pwdata[0];
      if (wr && hit_chm)  slot_mask <= pwdata;
      if (wr && hit_mask) irq_mask <= pwdata[15:0];
      if (wr && hit_cnt)  emit_cnt <= 16'h0000;
      else if (taken)     emit_cnt <= emit_cnt + 16'h0001;
    end
  end

  // Read mux, registered so data comes from flip-flops.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) rd_mux = {31'h0000_0000, enable};
    if (hit_stat) rd_mux = {16'h0000, irq_stat};
    if (hit_mask) rd_mux = {16'h0000, irq_mask};
    if (hit_desc) rd_mux = desc_word;
    if (hit_chm)  rd_mux = slot_mask;
    if (hit_cnt)  rd_mux = {16'h0000, emit_cnt};
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // Codes 11 to 15 never leave the encoder.
  chk_no_reserved: assert property (@(posedge clk) disable iff (sys_rst)
    desc_valid |-> desc_word[`IDE_EVT_HI:`IDE_EVT_LO] <= `IDE_EVT_DUP)
    else $error("Reserved event code emitted.");
  chk_ack_code: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ide_pkg::IDE_IDLE && enable && ev_valid && req_done_ok)
      |=> desc_valid && desc_word[`IDE_EVT_HI:`IDE_EVT_LO] == `IDE_EVT_ACK)
    else $error("Acknowledge not emitted as code 1.");
  chk_err_alone: assert property (@(posedge clk) disable iff (sys_rst)
    desc_valid && desc_word[`IDE_EVT_HI:`IDE_EVT_LO] > `IDE_EVT_MSG
      |-> desc_word[`IDE_ERR_HI:`IDE_ERR_LO] == `IDE_ERR_NONE)
    else $error("Error combined with a stand-alone event.");
  chk_buf_gate: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) && desc_word[`IDE_EVT_HI:`IDE_EVT_LO] == `IDE_EVT_BUF
      |-> $past(buf_done_notify_enable))
    else $error("Buffer done without notify enable.");
  chk_pad_tx: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) && desc_word[`IDE_EVT_HI:`IDE_EVT_LO] == `IDE_EVT_PAD
      |-> desc_word[`IDE_BIT_DIR] && $past(pad_count) != 8'h00)
    else $error("Padfill event on receive or zero pad count.");
  chk_ss7_rx: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) && desc_word[`IDE_EVT_HI:`IDE_EVT_LO] == `IDE_EVT_MUP
      |-> !desc_word[`IDE_BIT_DIR] && $past(ss7_mode))
    else $error("Monitor event outside SS7 receive.");
  chk_set_split: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) |-> desc_word[`IDE_BIT_GRPMSB] == $past(ev_group[2])
      && desc_word[`IDE_SET_HI:`IDE_SET_LO] == $past(ev_group[1:0]))
    else $error("Group number misplaced.");
  chk_hold_word: assert property (@(posedge clk) disable iff (sys_rst)
    desc_valid && !desc_ready |=> desc_valid && $stable(desc_word))
    else $error("Descriptor dropped before taken.");

  // Field view of the emitted event code for the checks below.
  wire [3:0] out_code = desc_word[`IDE_EVT_HI:`IDE_EVT_LO];

  // The slot index travels unchanged into its field.
  chk_slot_field: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) |-> desc_word[`IDE_SLOT_HI:`IDE_SLOT_LO] == $past(ev_slot))
    else $error("Slot index misplaced.");
  // Buffer completion reports the byte count that came with it.
  chk_buf_count: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) && out_code == `IDE_EVT_BUF
      |-> desc_word[`IDE_CNT_HI:0] == $past(byte_count_field))
    else $error("Byte count lost on buffer done.");
  // Message completion comes only from a message done pulse.
  chk_msg_src: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) && out_code == `IDE_EVT_MSG |-> $past(msg_done))
    else $error("Message done without its pulse.");
  // Padfill end needs both the done pulse and the channel's enable.
  chk_pad_src: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) && out_code == `IDE_EVT_PAD
      |-> $past(pad_done) && $past(pad_notify_enable))
    else $error("Padfill end without pulse or enable.");
  // A change to abort fill is reported on receive with the abort octet present.
  chk_abort_src: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) && out_code == `IDE_EVT_ABTF
      |-> !desc_word[`IDE_BIT_DIR] && $past(fill_octet) == `IDE_FILL_ABORT)
    else $error("Abort fill change misreported.");
  // A change to idle fill is reported on receive with the idle octet present.
  chk_idle_src: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) && out_code == `IDE_EVT_IDLF
      |-> !desc_word[`IDE_BIT_DIR] && $past(fill_octet) == `IDE_FILL_IDLE)
    else $error("Idle fill change misreported.");
  // Frame recovery follows a falling framing lost level and is always receive.
  chk_frame_rx: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) && out_code == `IDE_EVT_FRAME
      |-> !desc_word[`IDE_BIT_DIR] && $past(frame_lost_q) && !$past(framing_lost))
    else $error("Frame recovery without a framing edge.");
  // Monitor count up needs its pulse.
  chk_mup_src: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) && out_code == `IDE_EVT_MUP |-> $past(monitor_up))
    else $error("Monitor up without its pulse.");
  // Monitor count down is an SS7 receive event with its pulse.
  chk_mdn_rx: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) && out_code == `IDE_EVT_MDN
      |-> !desc_word[`IDE_BIT_DIR] && $past(ss7_mode) && $past(monitor_down))
    else $error("Monitor down outside SS7 receive.");
  // A dropped duplicate is reported only while the discard strobe stood.
  chk_dup_rx: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) && out_code == `IDE_EVT_DUP
      |-> !desc_word[`IDE_BIT_DIR] && $past(dup_discard))
    else $error("Duplicate report without a discard.");
  // Maskable events never leave a masked slot.
  chk_mask_drop: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) && out_code > `IDE_EVT_ACK |-> !$past(slot_mask[ev_slot]))
    else $error("Masked slot reported an event.");
  // Completion events carry the error code they were given.
  chk_err_slot: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(desc_valid) && (out_code == `IDE_EVT_BUF || out_code == `IDE_EVT_MSG)
      |-> desc_word[`IDE_ERR_HI:`IDE_ERR_LO] == $past(ev_error))
    else $error("Error code lost on completion.");
  // Status bits stay set until a status read takes them.
  chk_stat_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    !stat_rd |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
    else $error("Status bit cleared without a read.");
endmodule

// ---- ide_fill_watch.sv ----
// Watches the received pad fill octet and reports changes between idle and abort.
`timescale 1ns/1ps
module ide_fill_watch (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       fill_valid,
  input  wire logic [7:0] fill_octet,
  output logic            to_abort,
  output logic            to_idle
);
  `include "ide_map.svh"
  logic [7:0] last_fill;
  logic       seen;
  wire        is_idle  = (fill_octet == `IDE_FILL_IDLE);
  wire        is_abort = (fill_octet == `IDE_FILL_ABORT);
  wire        was_idle = seen && (last_fill == `IDE_FILL_IDLE);
  wire        was_abt  = seen && (last_fill == `IDE_FILL_ABORT);

  // Only the two recognised fill codes update the history, so stray octets do not rearm it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_fill <= 8'h00;
      seen      <= 1'b0;
    end else if (fill_valid && (is_idle || is_abort)) begin
      last_fill <= fill_octet;
      seen      <= 1'b1;
    end
  end

  // Change pulses are combinational and last one cycle with the valid octet.
  assign to_abort = fill_valid && is_abort && was_idle;
  assign to_idle  = fill_valid && is_idle && was_abt;
endmodule

// ---- ide_host_model.sv ----
// Host side model that drains interrupt descriptors after a chosen delay.
`timescale 1ns/1ps
module ide_host_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        desc_valid,
  input  wire logic [31:0] desc_word,
  input  wire logic [3:0]  delay,
  output logic             desc_ready,
  output logic             took,
  output logic [31:0]      took_word
);
  logic [3:0] waited;
  // Ready rises only after the host has waited, so a slow queue can stall the encoder.
  assign desc_ready = desc_valid && (waited >= delay);
  // Count the wait, flag each accepted word for one cycle and keep it until the next.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      waited <= 4'h0;
      took <= 1'b0;
      took_word <= 32'h0;
    end else begin
      waited <= (desc_valid && !desc_ready) ? waited + 4'h1 : 4'h0;
      took <= desc_valid && desc_ready;
      if (desc_valid && desc_ready) begin
        took_word <= desc_word;
      end
    end
  end
endmodule

// ---- ide_map.svh ----
// Register map, descriptor field positions and event codes for the descriptor encoder.
// Summary of operation
// - Group low two bits in 30:29, group top bit in bit 14.
// - Event code sits in bits 23:20; zero means no event.
// - A successful service request emits event code 1; failures raise other reports.
// - Code 2 only when a buffer finishes with its notify enable set; exact count.
// - Code 3 after the buffer holding the message's last octet.
// - Code 4 on transmit when padfill ends, pad count nonzero and enabled.
// - Code 5 on receive when pad fill changes from 7Eh to FFh.
// - Code 6 on receive when pad fill changes from FFh to 7Eh.
// - Code 7 on receive when a port leaves framing lost.
// - Code 8 in SS7 receive when the error monitor counts up.
// - Code 9 in SS7 receive when the error monitor counts down.
// - Code 10 in SS7 when a duplicate message is dropped, not stored.
// - Error code sits in bits 19:16; zero means no error.
// - Only buffer or message completion may carry an error; others stand alone.
`ifndef IDE_MAP_SVH
`define IDE_MAP_SVH
`define IDE_REG_CTRL      12'h000
`define IDE_REG_STAT      12'h004
`define IDE_REG_MASK      12'h008
`define IDE_REG_DESC      12'h00C
`define IDE_REG_CHMASK    12'h010
`define IDE_REG_CNT       12'h014
`define IDE_BIT_DIR       31
`define IDE_SET_HI        30
`define IDE_SET_LO        29
`define IDE_SLOT_HI       28
`define IDE_SLOT_LO       24
`define IDE_EVT_HI        23
`define IDE_EVT_LO        20
`define IDE_ERR_HI        19
`define IDE_ERR_LO        16
`define IDE_BIT_GRPMSB    14
`define IDE_CNT_HI        13
`define IDE_EVT_NONE      4'h0
`define IDE_EVT_ACK       4'h1
`define IDE_EVT_BUF       4'h2
`define IDE_EVT_MSG       4'h3
`define IDE_EVT_PAD       4'h4
`define IDE_EVT_ABTF      4'h5
`define IDE_EVT_IDLF      4'h6
`define IDE_EVT_FRAME     4'h7
`define IDE_EVT_MUP       4'h8
`define IDE_EVT_MDN       4'h9
`define IDE_EVT_DUP       4'hA
`define IDE_ERR_NONE      4'h0
`define IDE_FILL_IDLE     8'h7E
`define IDE_FILL_ABORT    8'hFF
`define IDE_NUM_EVT       10
`endif

// ---- ide_pkg.sv ----
// Types shared by the descriptor encoder files.
package ide_pkg;
  typedef logic [3:0] ide_code_t;
  typedef logic [31:0] ide_word_t;
  typedef enum logic [2:0] {
    IDE_IDLE = 3'h1,
    IDE_EMIT = 3'h2,
    IDE_HOLD = 3'h4
  } ide_state_e;
endpackage

// ---- interrupt_descriptor_encoder_bench.sv ----
// Self-checking bench for the descriptor encoder.
`timescale 1ns/1ps
module interrupt_descriptor_encoder_bench;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, desc_word, took_word;
  logic        ev_valid, ev_dir, nen, pne, framing_lost, ss7, dup_discard;
  logic        desc_valid, desc_ready, took;
  logic [3:0]  ev_group, ev_error, delay;
  logic [4:0]  ev_slot;
  logic [7:0]  pul, pcnt, fill_octet;
  logic [13:0] bcnt;
  int          n_fail, n_compared, n_taken;
  logic [3:0]  cs [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA};
  ide_encoder uut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .ev_valid(ev_valid), .ev_dir(ev_dir),
    .ev_group(ev_group), .ev_slot(ev_slot), .req_done_ok(pul[0]), .buf_done(pul[1]),
    .buf_done_notify_enable(nen), .msg_done(pul[2]), .byte_count_field(bcnt),
    .ev_error(ev_error), .pad_done(pul[3]), .pad_count(pcnt), .pad_notify_enable(pne),
    .fill_valid(pul[4]), .fill_octet(fill_octet), .framing_lost(framing_lost),
    .ss7_mode(ss7), .monitor_up(pul[5]), .monitor_down(pul[6]), .dup_unit(pul[7]),
    .dup_discard(dup_discard), .desc_word(desc_word), .desc_valid(desc_valid),
    .desc_ready(desc_ready));
  ide_host_model host (.clk(clk), .sys_rst(sys_rst), .desc_valid(desc_valid),
    .desc_word(desc_word), .delay(delay), .desc_ready(desc_ready), .took(took),
    .took_word(took_word));
  // Free-running 50 MHz clock.
  always #10 clk = ~clk;
  // Expected descriptor; code 7 is always reported as receive.
  function automatic logic [31:0] exp_w(logic [3:0] c, logic d, logic [2:0] g,
                                        logic [4:0] s, logic [3:0] e, logic [13:0] n);
    exp_w = {(c == 4'h7) ? 1'b0 : d, g[1:0], s, c,
             (c == 4'h2 || c == 4'h3) ? e : 4'h0, 1'b0, g[2], (c == 4'h2) ? n : 14'h0};
  endfunction
  // Pulse line that raises each event code; code 7 has none.
  function automatic logic [7:0] pbit(logic [3:0] c);
    pbit = (c < 4'h5) ? 8'h1 << (c - 4'h1) : (c < 4'h7) ? 8'h10
         : (c == 4'h7) ? 8'h0 : 8'h1 << (c - 4'h3);
  endfunction
  // Verdict printed in one place for the whole run.
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic stop_hang();
    n_fail++;
    wrap_up();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("BAD t=%0t got %h expected %h", $time, g, x);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 8) stop_hang();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Prime the fill and framing history, then present one event for a single cycle.
  task automatic ev(input logic [3:0] c, input logic d, input logic [2:0] g,
                    input logic [4:0] s, input logic [3:0] e, input logic [13:0] n);
    @(posedge clk);
    pul <= {3'h0, c == 4'h5 || c == 4'h6, 4'h0};
    fill_octet <= (c == 4'h6) ? 8'hFF : 8'h7E;
    framing_lost <= (c == 4'h7);
    // The new direction must stand already, or receive fill octets never reach the watcher.
    ev_dir <= d;
    @(posedge clk);
    {ev_valid, ev_dir, ev_group, ev_slot, ev_error, bcnt} <= {1'b1, d, 1'b0, g, s, e, n};
    pul <= pbit(c);
    fill_octet <= (c == 4'h5) ? 8'hFF : 8'h7E;
    framing_lost <= 1'b0;
    #1;
    chk({31'h0, dup_discard}, {31'h0, c == 4'hA && ss7 && !d});
    @(posedge clk);
    ev_valid <= 1'b0;
    pul <= 8'h0;
  endtask
  // Wait, bounded, for the host to take a descriptor, or make sure none comes.
  task automatic wt(input bit take, input logic [31:0] x);
    int k;
    for (k = 0; k < 24; k++) begin
      @(posedge clk);
      #1;
      if (took) break;
    end
    if (take && k == 24) stop_hang();
    if (take) n_taken++;
    chk(take ? took_word : {31'h0, took}, take ? x : 32'h0);
  endtask
  initial begin
    logic [31:0] r;
    logic [31:0] x;
    logic e;
    logic [3:0] c;
    logic d;
    int i;
    {clk, psel, penable, pwrite, paddr, pwdata, ev_valid, ev_dir, ev_group} = '0;
    {ev_slot, pul, fill_octet, framing_lost, bcnt, ev_error, delay} = '0;
    {n_fail, n_compared, n_taken} = '0;
    {nen, pne, ss7, pcnt, sys_rst} = {1'b1, 1'b1, 1'b1, 8'h03, 1'b1};
    void'($urandom(32'h27C1));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    ev(4'h1, 1'b0, 3'h0, 5'h0, 4'h0, 14'h0);
    wt(0, 32'h0);
    apb(1, 12'h000, 32'h1, r, e);
    apb(1, 12'h014, 32'h0, r, e);
    $display("test enable done");
    for (i = 1; i <= 10; i++) begin
      c = i;
      d = (c == 4'h4 || c == 4'h7) ? 1'b1 : (c > 4'h4) ? 1'b0 : c[0];
      delay = $urandom_range(0, 3);
      ev(c, d, c[2:0], 5'h1F - i, c, 14'h3FFF - i);
      wt(1, exp_w(c, d, c[2:0], 5'h1F - i, c, 14'h3FFF - i));
    end
    $display("test codes done");
    nen <= 1'b0;
    ev(4'h2, 1'b0, 3'h1, 5'h2, 4'h0, 14'h10);
    wt(0, 32'h0);
    {nen, pcnt} <= {1'b1, 8'h00};
    ev(4'h4, 1'b1, 3'h1, 5'h2, 4'h0, 14'h0);
    wt(0, 32'h0);
    {pcnt, pne} <= {8'h03, 1'b0};
    ev(4'h4, 1'b1, 3'h1, 5'h2, 4'h0, 14'h0);
    wt(0, 32'h0);
    {pne, ss7} <= {1'b1, 1'b0};
    ev(4'h8, 1'b0, 3'h1, 5'h2, 4'h0, 14'h0);
    wt(0, 32'h0);
    ss7 <= 1'b1;
    apb(1, 12'h010, 32'h20, r, e);
    ev(4'h2, 1'b0, 3'h3, 5'h5, 4'h1, 14'h9);
    wt(0, 32'h0);
    ev(4'h1, 1'b1, 3'h3, 5'h5, 4'h0, 14'h0);
    wt(1, exp_w(4'h1, 1'b1, 3'h3, 5'h5, 4'h0, 14'h0));
    apb(1, 12'h010, 32'h0, r, e);
    $display("test masks done");
    delay = 4'hF;
    ev(4'h1, 1'b0, 3'h5, 5'h7, 4'h0, 14'h0);
    ev(4'h3, 1'b0, 3'h5, 5'h7, 4'h2, 14'h0);
    wt(1, exp_w(4'h1, 1'b0, 3'h5, 5'h7, 4'h0, 14'h0));
    wt(0, 32'h0);
    delay = 4'h0;
    $display("test stall done");
    apb(0, 12'h004, 32'h0, r, e);
    apb(1, 12'h008, 32'h0, r, e);
    ev(4'h1, 1'b0, 3'h2, 5'h9, 4'h0, 14'h0);
    wt(1, exp_w(4'h1, 1'b0, 3'h2, 5'h9, 4'h0, 14'h0));
    chk({31'h0, irq}, 32'h0);
    apb(1, 12'h008, 32'h2, r, e);
    #1;
    chk({31'h0, irq}, 32'h1);
    apb(0, 12'h004, 32'h0, r, e);
    chk(r, 32'h2);
    #1;
    chk({31'h0, irq}, 32'h0);
    apb(0, 12'h00C, 32'h0, r, e);
    chk(r, exp_w(4'h1, 1'b0, 3'h2, 5'h9, 4'h0, 14'h0));
    apb(0, 12'h018, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    $display("test registers done");
    for (i = 0; i < 24; i++) begin
      c = cs[$urandom_range(0, 6)];
      d = (c == 4'h4) ? 1'b1 : (c > 4'h4) ? 1'b0 : 1'($urandom);
      x = $urandom;
      delay = $urandom_range(0, 4);
      ev(c, d, x[2:0], x[7:3], x[11:8], x[25:12]);
      wt(1, exp_w(c, d, x[2:0], x[7:3], x[11:8], x[25:12]));
    end
    apb(0, 12'h014, 32'h0, r, e);
    chk(r, n_taken);
    $display("test random done");
    wrap_up();
  end
  // Hard ceiling on run length in case a handshake never completes.
  initial begin
    #1000000;
    stop_hang();
  end
endmodule
